// [acq_pkg.sv]
// Shared constants and types for the acquisition buffer controller.
package acq_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned DEPTH_MAX_DEF   = 32'h0002_0000;
  localparam int unsigned SEG_LOG_MAX_DEF = 32'h0000_0006;
  localparam int unsigned SAMPLE_W_DEF    = 32'h0000_0020;
  localparam int unsigned RAM_KIND_DEF    = 32'h0000_0000;

  // ==========================================================================
  // Trigger position codes and the shifts that size the post-trigger part
  localparam logic [1:0] TPOS_PRE    = 2'h0;
  localparam logic [1:0] TPOS_CENTER = 2'h1;
  localparam logic [1:0] TPOS_POST   = 2'h2;
  localparam int unsigned TPOS_MINOR_SHIFT = 32'h0000_0003;
  localparam int unsigned TPOS_HALF_SHIFT  = 32'h0000_0001;

  // ==========================================================================
  // Controller states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FILL = 4'b0010,
    ST_POST = 4'b0100,
    ST_DONE = 4'b1000
  } acq_state_e;

  localparam acq_state_e ST_RESET = ST_IDLE;

endpackage : acq_pkg

// [acq_sample_store.sv]
// Inferred sample memory with one write port and one registered read port.
`timescale 1ns/1ps
module acq_sample_store
  import acq_pkg::*;
#(
  parameter int unsigned SAMPLE_W = SAMPLE_W_DEF,
  parameter int unsigned DEPTH    = DEPTH_MAX_DEF,
  parameter int unsigned RAM_KIND = RAM_KIND_DEF,
  parameter int unsigned AW       = $clog2(DEPTH)
) (
  // Clock
  input  wire logic                clk_i,
  // Write side
  input  wire logic                we_i,
  input  wire logic [AW-1:0]       waddr_i,
  input  wire logic [SAMPLE_W-1:0] wdata_i,
  // Read side
  input  wire logic [AW-1:0]       raddr_i,
  output logic      [SAMPLE_W-1:0] rdata_o
);

  // RAM_KIND is passed in but not used here; nothing in this module tells the
  // tools which block kind to map this array onto.
  logic [SAMPLE_W-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end

endmodule : acq_sample_store

// [acq_buffer_ctrl.sv]
// Capture-buffer controller of the embedded logic analyzer.
`timescale 1ns/1ps
module acq_buffer_ctrl
  import acq_pkg::*;
#(
  parameter int unsigned SAMPLE_W    = SAMPLE_W_DEF,
  parameter int unsigned DEPTH_MAX   = DEPTH_MAX_DEF,
  parameter int unsigned SEG_LOG_MAX = SEG_LOG_MAX_DEF,
  parameter int unsigned RAM_KIND    = RAM_KIND_DEF,
  parameter int unsigned AW          = $clog2(DEPTH_MAX),
  parameter int unsigned DW          = AW + 1,
  parameter int unsigned SSW         = $clog2(SEG_LOG_MAX + 1),
  parameter int unsigned SEGW        = (SEG_LOG_MAX > 0) ? SEG_LOG_MAX : 1
) (
  // Clock and reset
  input  wire logic                CORE_CLK_I,
  input  wire logic                RST_N_I,
  // Configuration, taken when armed
  input  wire logic                ARM_I,
  input  wire logic                SEGMENTED_I,
  input  wire logic [SSW-1:0]      SEG_SHIFT_I,
  input  wire logic [DW-1:0]       DEPTH_I,
  input  wire logic [1:0]          TRIG_POS_I,
  input  wire logic                QUAL_EN_I,
  // Tapped design signals and trigger evaluator
  input  wire logic [SAMPLE_W-1:0] DATA_I,
  input  wire logic                QUAL_I,
  input  wire logic                TRIG_I,
  // Readout
  input  wire logic [AW-1:0]       RD_ADDR_I,
  output logic      [SAMPLE_W-1:0] RD_DATA_O,
  // Status
  output logic                     RUNNING_O,
  output logic                     TRIGGERED_O,
  output logic                     ACQ_DONE_O,
  output logic      [SEGW-1:0]     ACTIVE_SEG_O,
  output logic      [AW-1:0]       TRIG_ADDR_O
);

  // ==========================================================================
  // Latched configuration, state and capture counters
  acq_state_e      st_q, st_d;
  logic [DW-1:0]   seg_depth_q;
  logic [SSW-1:0]  shift_q;
  logic [1:0]      pos_q;
  logic            seg_mode_q;
  logic            qual_en_q;
  logic [SEGW-1:0] seg_idx_q;
  logic [AW-1:0]   base_q;
  logic [AW-1:0]   off_q;
  logic [DW-1:0]   fill_q;
  logic [DW-1:0]   post_left_q;
  logic [AW-1:0]   trig_addr_q;

  // Depth requests above what was built are clamped to the built size.
  wire [DW-1:0] depth_clamp_w = (DEPTH_I > DW'(DEPTH_MAX)) ? DW'(DEPTH_MAX) : DEPTH_I;
  // A shift beyond the built segment count would leave part of the memory unused.
  wire shift_big_w            = (SEG_SHIFT_I > SSW'(SEG_LOG_MAX));
  wire [SSW-1:0] shift_w      = !SEGMENTED_I ? '0 :
                                shift_big_w  ? SSW'(SEG_LOG_MAX) : SEG_SHIFT_I;
  // Equal segments; a depth not divisible leaves a small unused tail.
  wire [DW-1:0] seg_depth_w   = depth_clamp_w >> shift_w;

  // ==========================================================================
  // Decode
  wire capturing_w = (st_q == ST_FILL) || (st_q == ST_POST);
  wire qual_pass_w = seg_mode_q || !qual_en_q || QUAL_I;
  wire we_w        = capturing_w && qual_pass_w;
  wire [AW-1:0] wr_addr_w = AW'(base_q + off_q);
  wire off_wrap_w  = ({1'b0, off_q} == seg_depth_q - DW'(1));
  wire [AW-1:0] off_inc_w = off_wrap_w ? '0 : AW'(off_q + AW'(1));
  wire full_w      = (fill_q == seg_depth_q);
  wire [SEGW-1:0] seg_last_w = SEGW'((DW'(1) << shift_q) - DW'(1));
  wire last_seg_w  = !seg_mode_q || (seg_idx_q == seg_last_w);

  // Share of the buffer kept after the trigger, by trigger position.
  wire [DW-1:0] minor_w = seg_depth_q >> TPOS_MINOR_SHIFT;
  wire [DW-1:0] post_cnt_w =
    (pos_q == TPOS_PRE)    ? DW'(seg_depth_q - minor_w) :
    (pos_q == TPOS_CENTER) ? (seg_depth_q >> TPOS_HALF_SHIFT) :
                             minor_w;

  // Trigger is judged every ST_FILL cycle, independent of the storage qualifier.
  wire trig_hit_w = (st_q == ST_FILL) && TRIG_I;
  wire seg_end_w  = (trig_hit_w && (post_cnt_w == '0)) ||
                    ((st_q == ST_POST) && we_w && (post_left_q == DW'(1)));
  wire seg_adv_w  = seg_end_w && !last_seg_w;

  // ==========================================================================
  // State machine
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: st_d = ST_IDLE;
      ST_FILL: begin
        if (seg_end_w) begin
          st_d = last_seg_w ? ST_DONE : ST_FILL;
        end else if (trig_hit_w) begin
          st_d = ST_POST;
        end
      end
      ST_POST: begin
        if (seg_end_w) begin
          st_d = last_seg_w ? ST_DONE : ST_FILL;
        end
      end
      ST_DONE: st_d = ST_DONE;
      default: st_d = ST_IDLE;
    endcase
    if (ARM_I) begin
      st_d = (seg_depth_w == '0) ? ST_DONE : ST_FILL;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= ST_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Configuration capture
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seg_depth_q <= '0;
      shift_q     <= '0;
      pos_q       <= TPOS_PRE;
      seg_mode_q  <= 1'b0;
      qual_en_q   <= 1'b0;
    end else if (ARM_I) begin
      seg_depth_q <= seg_depth_w;
      shift_q     <= shift_w;
      pos_q       <= TRIG_POS_I;
      seg_mode_q  <= SEGMENTED_I;
      qual_en_q   <= QUAL_EN_I;
    end
  end

  // ==========================================================================
  // Pointers and counters
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      seg_idx_q   <= '0;
      base_q      <= '0;
      off_q       <= '0;
      fill_q      <= '0;
      post_left_q <= '0;
    end else if (ARM_I) begin
      seg_idx_q   <= '0;
      base_q      <= '0;
      off_q       <= '0;
      fill_q      <= '0;
      post_left_q <= '0;
    end else if (seg_adv_w) begin
      seg_idx_q   <= SEGW'(seg_idx_q + SEGW'(1));
      base_q      <= AW'(base_q + seg_depth_q);
      off_q       <= '0;
      fill_q      <= '0;
      post_left_q <= '0;
    end else begin
      if (we_w) begin
        off_q  <= off_inc_w;
        fill_q <= full_w ? fill_q : DW'(fill_q + DW'(1));
      end
      if (trig_hit_w) begin
        post_left_q <= post_cnt_w;
      end else if ((st_q == ST_POST) && we_w) begin
        post_left_q <= DW'(post_left_q - DW'(1));
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      trig_addr_q <= '0;
    end else if (trig_hit_w) begin
      trig_addr_q <= wr_addr_w;
    end
  end

  // ==========================================================================
  // Storage
  acq_sample_store #(
    .SAMPLE_W (SAMPLE_W),
    .DEPTH    (DEPTH_MAX),
    .RAM_KIND (RAM_KIND),
    .AW       (AW)
  ) u_store (
    .clk_i   (CORE_CLK_I),
    .we_i    (we_w),
    .waddr_i (wr_addr_w),
    .wdata_i (DATA_I),
    .raddr_i (RD_ADDR_I),
    .rdata_o (RD_DATA_O)
  );

  assign RUNNING_O    = capturing_w;
  assign TRIGGERED_O  = (st_q == ST_POST);
  assign ACQ_DONE_O   = (st_q == ST_DONE);
  assign ACTIVE_SEG_O = seg_idx_q;
  assign TRIG_ADDR_O  = trig_addr_q;

  // ==========================================================================
  // Checks
  one_seg_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    we_w |-> ({1'b0, wr_addr_w} >= {1'b0, base_q}) &&
             ({1'b0, wr_addr_w} < DW'({1'b0, base_q} + seg_depth_q)))
    else $error("Write landed outside the active segment.");

  done_stop_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q == ST_DONE) && !ARM_I |=> (st_q == ST_DONE) && !we_w && ACQ_DONE_O)
    else $error("Capture resumed after completion without arming.");

  qual_drop_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    capturing_w && !seg_mode_q && qual_en_q && !QUAL_I && !ARM_I |-> !we_w ##1 $stable(off_q))
    else $error("Unqualified sample was stored.");

  qual_keep_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    capturing_w && QUAL_I |-> we_w)
    else $error("Qualified sample was not stored.");

  wrap_oldest_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    we_w && off_wrap_w && full_w && !ARM_I && !seg_adv_w |=>
      (off_q == '0) && (fill_q == $past(fill_q)))
    else $error("Full buffer did not wrap onto its oldest sample.");

  seg_advance_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    seg_adv_w && !ARM_I |=> (st_q == ST_FILL) && (off_q == '0) &&
                            (seg_idx_q == SEGW'($past(seg_idx_q) + SEGW'(1))))
    else $error("Segment did not advance after its trigger.");

  post_count_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    trig_hit_w && (post_cnt_w != '0) && !ARM_I |=>
      (st_q == ST_POST) && (post_left_q == $past(post_cnt_w)))
    else $error("Post-trigger count not loaded from trigger position.");

  fifo_hold_a: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q == ST_FILL) && !TRIG_I && !ARM_I |=> (st_q == ST_FILL) && $stable(seg_idx_q))
    else $error("Capture left the FIFO phase without a trigger.");

endmodule : acq_buffer_ctrl

// [acq_tap_source.sv]
// Model of the tapped design: sample data, storage qualifier and trigger result.
`timescale 1ns/1ps
module acq_tap_source #(
  parameter int unsigned SAMPLE_W = 32
) (
  // Clock and control
  input  wire logic                clk_i,
  input  wire logic                trig_en_i,
  // Tapped signals
  output logic      [SAMPLE_W-1:0] data_o,
  output logic                     qual_o,
  output logic                     trig_o
);
  initial begin
    data_o = '0;
    qual_o = 1'b0;
    trig_o = 1'b0;
  end

  // ==========================================================================
  // New data every cycle, so a stale or skipped write shows up on readout.
  always @(posedge clk_i) begin
    data_o <= SAMPLE_W'($urandom);
    qual_o <= ($urandom_range(0, 3) != 0);
    trig_o <= trig_en_i && ($urandom_range(0, 15) == 0);
  end
endmodule : acq_tap_source

// [acquisition_buffer_ctrl_tb_top.sv]
// Self-checking testbench for the acquisition buffer controller.
`timescale 1ns/1ps
module acquisition_buffer_ctrl_tb_top;
  import acq_pkg::*;
  localparam int unsigned DMAX = 32'h0000_0040;
  localparam int unsigned SLM  = 32'h0000_0002;

  // ==========================================================================
  // Signals
  logic        clk, rst_n, arm, segm, qen, trig_en, qual, trig, running, triggered, done;
  logic [1:0]  sshift, tpos, aseg;
  logic [6:0]  depth;
  logic [5:0]  raddr, taddr;
  logic [31:0] data, rdata;
  int          miscompares, n_compared;
  int          st, sd, nseg, seg, base, off, npost, cnt, tad;
  bit          mseg, mqen, we, ended, tok;
  logic [31:0] mem [DMAX];
  bit          wr [DMAX];

  acq_tap_source #(.SAMPLE_W(32)) tap (.clk_i(clk), .trig_en_i(trig_en), .data_o(data),
    .qual_o(qual), .trig_o(trig));

  acq_buffer_ctrl #(.SAMPLE_W(32), .DEPTH_MAX(DMAX), .SEG_LOG_MAX(SLM)) DUT (
    .CORE_CLK_I(clk), .RST_N_I(rst_n), .ARM_I(arm), .SEGMENTED_I(segm),
    .SEG_SHIFT_I(sshift), .DEPTH_I(depth), .TRIG_POS_I(tpos), .QUAL_EN_I(qen),
    .DATA_I(data), .QUAL_I(qual), .TRIG_I(trig), .RD_ADDR_I(raddr), .RD_DATA_O(rdata),
    .RUNNING_O(running), .TRIGGERED_O(triggered), .ACQ_DONE_O(done),
    .ACTIVE_SEG_O(aseg), .TRIG_ADDR_O(taddr));

  // ==========================================================================
  // Reference model, stepped on the same edge with the same inputs.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st = 0;
      seg = 0;
      tok = 0;
    end else if (arm) begin
      // A capture that is still running stores the sample of the arm edge as well.
      if ((st == 1 || st == 2) && (mseg || !mqen || qual)) begin
        mem[base+off] = data;
        wr[base+off] = 1;
      end
      sd = ((depth > DMAX) ? DMAX : depth) >> (segm ? sshift : 0);
      nseg = segm ? (1 << sshift) : 1;
      npost = (tpos == TPOS_PRE) ? sd - (sd >> 3) : (tpos == TPOS_CENTER) ? sd >> 1 : sd >> 3;
      mseg = segm;
      mqen = qen;
      {seg, base, off, tok} = '0;
      st = (sd == 0) ? 3 : 1;
    end else if (st == 1 || st == 2) begin
      we = mseg || !mqen || qual;
      ended = 0;
      if (we) begin
        mem[base+off] = data;
        wr[base+off] = 1;
      end
      if (st == 1 && trig) begin
        tad = base + off;
        tok = 1;
        cnt = 0;
        st = 2;
        ended = (npost == 0);
      end else if (st == 2 && we) begin
        cnt++;
        ended = (cnt == npost);
      end
      if (we) off = (off + 1) % sd;
      if (ended && seg == nseg - 1) st = 3;
      else if (ended) begin
        seg++;
        base += sd;
        off = 0;
        st = 1;
      end
    end
  end

  // ==========================================================================
  // Compare tasks and closing report
  task automatic chk_stat(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: status got %h expected %h", $time, got, exp);
    end
  endtask : chk_stat

  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: sample got %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  always @(negedge clk) if (rst_n) begin
    chk_stat(8'({running, triggered, done}), 8'({st == 1 || st == 2, st == 2, st == 3}));
    chk_stat(8'(aseg), 8'(seg[1:0]));
    if (tok) chk_stat(8'(taddr), 8'(tad[5:0]));
  end

  // ==========================================================================
  // One acquisition; segmented, depth and qualifier settings are scrambled after arm, since they must be ignored then.
  task automatic run(input bit s, input bit [1:0] sh, input int d, input bit [1:0] p,
                     input bit q, input int rearm);
    int n;
    @(posedge clk);
    {arm, segm, sshift, depth, tpos, qen, trig_en} <= {1'b1, s, sh, 7'(d), p, q, 1'b1};
    @(posedge clk) {arm, segm, depth, qen} <= {1'b0, 9'($urandom)};
    if (rearm > 0) begin
      repeat (rearm) @(posedge clk);
      arm <= 1'b1;
      @(posedge clk) arm <= 1'b0;
    end
    // Look only once the arm edge has settled; before it the old done flag still stands.
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (done !== 1'b1 && n < 3000);
    if (done !== 1'b1) begin
      miscompares++;
      $display("mismatch at %0t: acquisition never completed", $time);
      print_verdict();
    end
    trig_en <= 1'b0;
    for (int a = 0; a < DMAX; a++) if (wr[a]) begin
      @(posedge clk) raddr <= 6'(a);
      @(posedge clk);
      @(negedge clk) chk_rd(rdata, mem[a]);
    end
  endtask : run

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    {rst_n, arm, segm, qen, trig_en, sshift, tpos, depth, raddr} = '0;
    void'($urandom(32'hb473_f522));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    run(0, 0, 8, 1, 0, 0);
    run(0, 0, 64, 0, 0, 0);
    run(0, 0, 100, 2, 1, 0);
    run(0, 0, 16, 3, 1, 5);
    run(1, 1, 32, 1, 1, 0);
    run(1, 2, 64, 0, 0, 0);
    run(1, 2, 8, 2, 0, 0);
    run(0, 0, 0, 1, 0, 0);
    run(1, 2, 3, 0, 0, 0);
    @(posedge clk) {arm, depth, trig_en} <= {1'b1, 7'(32), 1'b1};
    @(posedge clk) arm <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    print_verdict();
  end
endmodule : acquisition_buffer_ctrl_tb_top
